// ### hw/ccs_control_status.sv
// Purpose: CPU-side control, status, error counting and bus-off recovery of a
//          CAN protocol controller.
// Assumes: Protocol core signals are on clk; the receive pin is asynchronous.
// Notes:   Register port answers a read in the cycle after the strobe.
`timescale 1ns/100ps
`include "ccs_defines.svh"

module ccs_control_status
	import ccs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic can_rx_pin,
	output logic can_tx_pin,
	input wire logic core_tx,
	input wire logic core_sample_point,
	input wire logic core_rx_ok,
	input wire logic core_tx_ok,
	input wire logic core_err,
	input wire logic core_err_in_tx,
	input wire logic [2:0] core_err_code,
	input wire logic [15:0] msg_irq_id,
	output logic core_rx,
	output logic irq_n,
	output logic init_hold,
	output logic auto_retransmit_disable,
	output logic [15:0] bit_timing_q,
	output logic [3:0] brp_ext_q,
	output logic [15:0] tt_mode_q,
	output logic [6:0] test_q,
	output logic msg_flags_clear
);

	// ============================================================
	// Declarations
	logic [15:0] ctl_r;
	logic [15:0] bittime_r;
	logic [3:0] brpext_r;
	logic [15:0] ttmode_r;
	logic [6:0] test_r;
	logic [15:0] rdata_r;
	logic rx_meta_r;
	logic rx_sync_r;
	logic tx_r;
	logic core_rx_r;
	logic irq_n_r;
	logic clear_r;
	logic [8:0] tec_r;
	logic [7:0] rec_r;
	logic bus_off_flag_r;
	logic warn_r;
	logic receive_success_flag_r;
	logic transmit_success_flag_r;
	logic [2:0] lec_r;
	logic stirq_r;
	logic [3:0] bitcnt_r;
	logic [7:0] runcnt_r;
	ccs_state_type state_r;
	logic wr_ctl;
	logic wr_status;
	logic cfg_open;
	logic warn_nxt;
	logic passive;
	logic bus_off_flag_enter;
	logic idle_run;
	logic recover_done;
	logic err_evt;
	logic sie_evt;
	logic eie_evt;
	logic [15:0] intid;
	logic [15:0] rd_mux;
	logic [7:0] word_addr;
	logic [15:0] test_wdata;

	// ============================================================
	// Register decode
	// The low address bit picks a byte lane that this port does not carry, so
	// each access addresses the whole 16-bit word at the even address.
	assign word_addr = {reg_addr[7:1], 1'b0};
	assign wr_ctl = reg_wr && word_addr == `CCS_OFF_CONTROL;
	assign wr_status = reg_wr && word_addr == `CCS_OFF_STATUS;
	assign test_wdata = reg_wdata & `CCS_TEST_MASK;
	assign cfg_open = ctl_r[`CCS_CTL_CCE] && ctl_r[`CCS_CTL_INIT];

	// ============================================================
	// Error counters
	assign err_evt = core_err && state_r == CCS_ACTIVE;
	assign warn_nxt = tec_r >= `CCS_WARN_LIMIT || {1'b0, rec_r} >= `CCS_WARN_LIMIT;
	assign passive = tec_r > `CCS_PASS_LIMIT || {1'b0, rec_r} > `CCS_PASS_LIMIT;
	assign bus_off_flag_enter = state_r == CCS_ACTIVE && tec_r > `CCS_BUS_OFF_FLAG_LIMIT;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tec_r <= 9'h000;
			rec_r <= 8'h00;
		end
		else if (recover_done)
		begin
			tec_r <= 9'h000;
			rec_r <= 8'h00;
		end
		else if (state_r == CCS_ACTIVE)
		begin
			if (err_evt && core_err_in_tx)
				tec_r <= tec_r + 9'h008;
			else if (core_tx_ok && tec_r != 9'h000)
				tec_r <= tec_r - 9'h001;
			if (err_evt && !core_err_in_tx && rec_r != 8'hFF)
				rec_r <= rec_r + 8'h01;
			else if (core_rx_ok && rec_r != 8'h00)
				rec_r <= rec_r - 8'h01;
		end
	end

	// ============================================================
	// Bus-off recovery: idle runs are counted at the core's sample points
	assign idle_run = state_r == CCS_RECOVER && core_sample_point && rx_sync_r
		&& bitcnt_r == `CCS_IDLE_BITS - 4'h1;
	assign recover_done = idle_run && runcnt_r == `CCS_IDLE_RUNS - 8'h01;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			state_r <= CCS_ACTIVE;
		else
		begin
			case (state_r)
				CCS_ACTIVE:
					if (bus_off_flag_enter)
						state_r <= CCS_BUSOFF;
				CCS_BUSOFF:
					if (!ctl_r[`CCS_CTL_INIT])
						state_r <= CCS_RECOVER;
				CCS_RECOVER:
					if (recover_done)
						state_r <= CCS_ACTIVE;
				default:
					state_r <= CCS_ACTIVE;
			endcase
		end
	end

	// A dominant sample restarts the run; setting init again does not.
	always_ff @(posedge clk)
	begin
		if (!rstn || state_r != CCS_RECOVER)
		begin
			bitcnt_r <= 4'h0;
			runcnt_r <= 8'h00;
		end
		else if (core_sample_point)
		begin
			if (!rx_sync_r || idle_run)
				bitcnt_r <= 4'h0;
			else
				bitcnt_r <= bitcnt_r + 4'h1;
			if (idle_run)
				runcnt_r <= runcnt_r + 8'h01;
		end
	end

	// ============================================================
	// Control and configuration registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
			ctl_r <= `CCS_RST_CONTROL;
		else if (bus_off_flag_enter)
			ctl_r <= ctl_r | 16'h0001;
		else if (wr_ctl)
			ctl_r <= reg_wdata & `CCS_CTL_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			bittime_r <= `CCS_RST_BITTIME;
			brpext_r <= 4'h0;
			ttmode_r <= `CCS_RST_ZERO;
		end
		else if (reg_wr && cfg_open)
		begin
			if (word_addr == `CCS_OFF_BITTIME)
				bittime_r <= reg_wdata & `CCS_BITTIME_MASK;
			if (word_addr == `CCS_OFF_BRPEXT)
				brpext_r <= reg_wdata[3:0];
			if (word_addr == `CCS_OFF_TTMODE)
				ttmode_r <= reg_wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			test_r <= 7'h00;
		else if (reg_wr && word_addr == `CCS_OFF_TEST && ctl_r[`CCS_CTL_TEST])
			test_r <= test_wdata[6:0];
	end

	// ============================================================
	// Status register
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			bus_off_flag_r <= 1'b0;
			warn_r <= 1'b0;
		end
		else
		begin
			bus_off_flag_r <= state_r != CCS_ACTIVE || bus_off_flag_enter;
			warn_r <= warn_nxt;
		end
	end

	// Bus events win over a software write in the same cycle.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			receive_success_flag_r <= 1'b0;
			transmit_success_flag_r <= 1'b0;
			lec_r <= `CCS_LEC_NONE;
		end
		else
		begin
			if (core_rx_ok)
				receive_success_flag_r <= 1'b1;
			else if (wr_status)
				receive_success_flag_r <= reg_wdata[`CCS_ST_RECEIVE_SUCCESS_FLAG];
			if (core_tx_ok)
				transmit_success_flag_r <= 1'b1;
			else if (wr_status)
				transmit_success_flag_r <= reg_wdata[`CCS_ST_TRANSMIT_SUCCESS_FLAG];
			if (idle_run)
				lec_r <= `CCS_LEC_BIT0;
			else if (err_evt)
				lec_r <= core_err_code;
			else if (core_rx_ok || core_tx_ok)
				lec_r <= `CCS_LEC_NONE;
			else if (wr_status)
				lec_r <= reg_wdata[2:0];
		end
	end

	// ============================================================
	// Status interrupt identifier
	// Only hardware events feed these terms, so passive changes and software
	// writes to the status word never raise the identifier.
	assign sie_evt = ctl_r[`CCS_CTL_SIE] && (core_rx_ok || core_tx_ok || err_evt || idle_run);
	assign eie_evt = ctl_r[`CCS_CTL_EIE] && (warn_r != warn_nxt
		|| bus_off_flag_r != (state_r != CCS_ACTIVE || bus_off_flag_enter));

	always_ff @(posedge clk)
	begin
		if (!rstn)
			stirq_r <= 1'b0;
		else if (sie_evt || eie_evt)
			stirq_r <= 1'b1;
		else if (reg_rd && word_addr == `CCS_OFF_STATUS)
			stirq_r <= 1'b0;
	end

	assign intid = stirq_r ? `CCS_STATUS_IRQ_ID : msg_irq_id;

	// ============================================================
	// Read path
	always_comb
	begin
		rd_mux = 16'h0000;
		case (word_addr)
			`CCS_OFF_CONTROL: rd_mux = ctl_r;
			`CCS_OFF_STATUS: rd_mux = {8'h00, bus_off_flag_r, warn_r, passive, receive_success_flag_r, transmit_success_flag_r, lec_r};
			`CCS_OFF_ERRCNT: rd_mux = {rec_r[7], rec_r[6:0], tec_r[7:0]};
			`CCS_OFF_BITTIME: rd_mux = bittime_r;
			`CCS_OFF_INTID: rd_mux = intid;
			`CCS_OFF_TEST: rd_mux = {8'h00, rx_sync_r, test_r};
			`CCS_OFF_BRPEXT: rd_mux = {12'h000, brpext_r};
			`CCS_OFF_TTMODE: rd_mux = ttmode_r;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata_r <= 16'h0000;
		else if (reg_rd)
			rdata_r <= rd_mux;
		else
			rdata_r <= 16'h0000;
	end

	// ============================================================
	// Pins and outputs
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end
		else
		begin
			rx_meta_r <= can_rx_pin;
			rx_sync_r <= rx_meta_r;
		end
	end

	// Test pin modes apply only while test enable is set, so a stale test
	// setting cannot disturb normal traffic.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			tx_r <= 1'b1;
		else if (ctl_r[`CCS_CTL_INIT] || state_r != CCS_ACTIVE || bus_off_flag_enter)
			tx_r <= 1'b1;
		else if (ctl_r[`CCS_CTL_TEST] && test_r[6:5] != 2'b00)
			tx_r <= test_r[6] ? test_r[5] : core_sample_point;
		else if (ctl_r[`CCS_CTL_TEST] && test_r[3])
			tx_r <= 1'b1;
		else
			tx_r <= core_tx;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			core_rx_r <= 1'b1;
			irq_n_r <= 1'b1;
			clear_r <= 1'b1;
		end
		else
		begin
			core_rx_r <= (ctl_r[`CCS_CTL_TEST] && test_r[4]) ? core_tx : rx_sync_r;
			irq_n_r <= !(ctl_r[`CCS_CTL_IE] && intid != 16'h0000);
			clear_r <= 1'b0;
		end
	end

	assign reg_rdata = rdata_r;
	assign can_tx_pin = tx_r;
	assign core_rx = core_rx_r;
	assign irq_n = irq_n_r;
	assign init_hold = ctl_r[`CCS_CTL_INIT];
	assign auto_retransmit_disable = ctl_r[`CCS_CTL_DAR];
	assign bit_timing_q = bittime_r;
	assign brp_ext_q = brpext_r;
	assign tt_mode_q = ttmode_r;
	assign test_q = test_r;
	assign msg_flags_clear = clear_r;

	// ============================================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_tx_recessive_init: assert property (ctl_r[`CCS_CTL_INIT] |=> can_tx_pin)
		else $error("transmit pin not recessive while init set");
	a_cfg_write_gate: assert property (reg_wr && reg_addr == `CCS_OFF_BITTIME && !cfg_open
		|=> $stable(bit_timing_q))
		else $error("bit timing changed while closed");
	a_test_write_gate: assert property (reg_wr && reg_addr == `CCS_OFF_TEST
		&& !ctl_r[`CCS_CTL_TEST] |=> $stable(test_q))
		else $error("test register changed without test enable");
	a_irq_disabled_high: assert property (!ctl_r[`CCS_CTL_IE] |=> irq_n)
		else $error("interrupt pin low while disabled");
	a_status_read_clear: assert property (reg_rd && reg_addr == `CCS_OFF_STATUS
		&& !sie_evt && !eie_evt |=> !stirq_r)
		else $error("status identifier survived status read");
	a_busoff_sets_init: assert property (bus_off_flag_enter |=> init_hold && state_r == CCS_BUSOFF)
		else $error("bus-off did not set init");
	a_recover_idle_code: assert property (idle_run && !recover_done
		|=> lec_r == `CCS_LEC_BIT0 && state_r == CCS_RECOVER)
		else $error("idle run did not write code 5");
	a_recover_clears: assert property (recover_done |=> tec_r == 9'h000 && rec_r == 8'h00
		##1 !bus_off_flag_r)
		else $error("counters not cleared after recovery");
	a_warn_level: assert property (tec_r >= `CCS_WARN_LIMIT |=> warn_r)
		else $error("warning flag missing");
	a_receive_success_flag_sticky: assert property (receive_success_flag_r && !wr_status |=> receive_success_flag_r)
		else $error("receive-ok cleared by hardware");
	a_sie_event_irq: assert property (ctl_r[`CCS_CTL_SIE] && core_rx_ok |=> stirq_r)
		else $error("valid message raised no status interrupt");
	a_good_clears_lec: assert property (core_tx_ok && !err_evt && !idle_run
		|=> lec_r == `CCS_LEC_NONE)
		else $error("error-free transfer left error code");

endmodule

// ### hw/ccs_defines.svh
// Purpose: Register offsets, field positions, reset values and counts of the
//          CAN control and status block.
// Assumes: 16-bit registers at even byte addresses in a 256-byte window.
// Notes:   Shared by the package user and the design module.
//
// Notes on behaviour
// - 256-byte window of 16-bit registers, high byte odd, low byte even; the port ignores the low address bit and moves whole words.
// - Reset leaves bus-off and drives the transmit pin recessive.
// - Control resets to 0x0001; no bus driving until software clears init.
// - Reset clears only valid, new-data, send-request and pending bits of memory.
// - Configuration writes need both change-enable and init set.
// - Write protection covers bit timing, prescaler extension and TT mode.
// - Interrupt pin low while any pending and enabled; high when disabled.
// - Bus-off/warning changes irq with error enable; ok/code with status enable.
// - Status enable raises irq on every bus error and every valid message; the code ignores bus errors during bus-off and recovery.
// - Error-passive changes and software status writes raise no irq.
// - Reading status clears a pending status identifier 8000h.
// - Entering bus-off sets init and stops bus activity; init cannot shorten it.
// - After init clears, wait 129 idle runs of 11 recessive bits.
// - Each 11-recessive run during recovery writes code 5 to last error code.
// - Recovery end resets both error counters.
// - Warning set while either counter is at least 96.
// - Receive-ok set on any good reception; only software clears it.
// - Transmit-ok set on acknowledged good transmission; only software clears it.
// - Last error code values 0 to 6 as the protocol core reports them.
// - Last error code cleared to 0 on any error-free transfer.
// - Software may write 7; it stays until the next bus event.
// - Test register writes accepted only while test enable is set.
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ============================================================
// Register offsets
`define CCS_OFF_CONTROL 8'h00
`define CCS_OFF_STATUS 8'h02
`define CCS_OFF_ERRCNT 8'h04
`define CCS_OFF_BITTIME 8'h06
`define CCS_OFF_INTID 8'h08
`define CCS_OFF_TEST 8'h0A
`define CCS_OFF_BRPEXT 8'h0C
`define CCS_OFF_TTMODE 8'h28

// ============================================================
// Reset values
`define CCS_RST_CONTROL 16'h0001
`define CCS_RST_BITTIME 16'h2301
`define CCS_RST_ZERO 16'h0000
`define CCS_STATUS_IRQ_ID 16'h8000

// ============================================================
// Control fields
`define CCS_CTL_INIT 0
`define CCS_CTL_IE 1
`define CCS_CTL_SIE 2
`define CCS_CTL_EIE 3
`define CCS_CTL_DAR 5
`define CCS_CTL_CCE 6
`define CCS_CTL_TEST 7
`define CCS_CTL_MASK 16'h00EF

// ============================================================
// Status fields, test fields and masks
`define CCS_ST_BUS_OFF_FLAG 7
`define CCS_ST_WARN 6
`define CCS_ST_PASS 5
`define CCS_ST_RECEIVE_SUCCESS_FLAG 4
`define CCS_ST_TRANSMIT_SUCCESS_FLAG 3
`define CCS_TEST_MASK 16'h007D
`define CCS_BRPEXT_MASK 16'h000F
`define CCS_BITTIME_MASK 16'h7FFF

// ============================================================
// Error codes and counts
`define CCS_LEC_NONE 3'h0
`define CCS_LEC_BIT0 3'h5
`define CCS_WARN_LIMIT 9'h060
`define CCS_PASS_LIMIT 9'h07F
`define CCS_BUS_OFF_FLAG_LIMIT 9'h0FF
`define CCS_IDLE_BITS 4'hB
`define CCS_IDLE_RUNS 8'h81

`endif

// ### hw/ccs_pkg.sv
// Purpose: Types of the CAN control and status block.
// Assumes: Constants live in ccs_defines.svh.
// Notes:   Recovery state only.
package ccs_pkg;

	// ============================================================
	// Bus-off recovery state
	typedef enum logic [1:0] {
		CCS_ACTIVE = 2'b00,
		CCS_BUSOFF = 2'b01,
		CCS_RECOVER = 2'b10
	} ccs_state_type;

endpackage

// ### verif/can_protocol_control_status_bench.sv
// Purpose: Self-checking bench of the CAN control and status block.
// Assumes: One clock; the receive pin is the wired-AND level of the node model.
// Notes:   Register rows first, then interrupts, error counting, bus-off and reset.
`timescale 1ns/100ps
module can_protocol_control_status_bench;
	typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} ccs_row_type;

	logic clk, rstn, reg_wr, reg_rd, core_tx, core_sample_point, core_rx_ok, core_tx_ok;
	logic core_err, core_err_in_tx, node_dom, can_rx_pin, can_tx_pin, irq_n, init_hold;
	logic msg_flags_clear, core_rx, auto_retransmit_disable;
	logic [3:0] brp_ext_q;
	logic [6:0] test_q;
	logic [15:0] bit_timing_q, tt_mode_q;
	logic [2:0] core_err_code;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, msg_irq_id, reg_rdata, v;
	int mismatches, n_checks, cyc, i;
	ccs_row_type rows [0:25] = '{
		'{1'b0, 8'h00, 16'h0000, 16'h0001}, '{1'b0, 8'h02, 16'h0000, 16'h0000},
		'{1'b0, 8'h04, 16'h0000, 16'h0000}, '{1'b0, 8'h06, 16'h0000, 16'h2301},
		'{1'b0, 8'h08, 16'h0000, 16'h0000}, '{1'b0, 8'h0A, 16'h0000, 16'h0080},
		'{1'b0, 8'h0C, 16'h0000, 16'h0000}, '{1'b0, 8'h26, 16'h0000, 16'h0000},
		'{1'b1, 8'h00, 16'hFFFF, 16'h00EF}, '{1'b1, 8'h06, 16'hFFFF, 16'h7FFF},
		'{1'b1, 8'h0C, 16'hFFFF, 16'h000F}, '{1'b1, 8'h28, 16'hFFFF, 16'hFFFF},
		'{1'b1, 8'h0A, 16'h007D, 16'h00FD}, '{1'b1, 8'h0A, 16'h0000, 16'h0080},
		'{1'b1, 8'h04, 16'hFFFF, 16'h0000}, '{1'b1, 8'h26, 16'hFFFF, 16'h0000},
		'{1'b1, 8'h00, 16'h0041, 16'h0041}, '{1'b1, 8'h0A, 16'h0010, 16'h0080},
		'{1'b1, 8'h00, 16'h0001, 16'h0001}, '{1'b1, 8'h07, 16'h1234, 16'h7FFF},
		'{1'b1, 8'h00, 16'h0040, 16'h0040}, '{1'b1, 8'h0C, 16'h0003, 16'h000F},
		'{1'b1, 8'h28, 16'h0000, 16'hFFFF}, '{1'b1, 8'h01, 16'h0041, 16'h0041},
		'{1'b1, 8'h06, 16'h2301, 16'h2301}, '{1'b1, 8'h00, 16'h0001, 16'h0001}};

	ccs_control_status dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .core_tx(core_tx),
		.core_sample_point(core_sample_point), .core_rx_ok(core_rx_ok),
		.core_tx_ok(core_tx_ok), .core_err(core_err), .core_err_in_tx(core_err_in_tx),
		.core_err_code(core_err_code), .msg_irq_id(msg_irq_id), .core_rx(core_rx),
		.irq_n(irq_n), .init_hold(init_hold),
		.auto_retransmit_disable(auto_retransmit_disable), .bit_timing_q(bit_timing_q),
		.brp_ext_q(brp_ext_q), .tt_mode_q(tt_mode_q), .test_q(test_q),
		.msg_flags_clear(msg_flags_clear));

	ccs_bus_node node_u (.dut_tx(can_tx_pin), .drive_dominant(node_dom), .bus_level(can_rx_pin));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ============================================================
	// Shared tasks
	task automatic end_sim;
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Flags are sampled one step past the edge so their update has landed.
	task automatic bchk(input logic seen, input logic exp);
		#1;
		chk({15'h0000, seen}, {15'h0000, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		chk(v & m, e);
		tick(1);
	endtask

	task automatic errs(input int n, input logic tx, input logic [2:0] code);
		repeat (n)
		begin
			core_err <= 1'b1;
			core_err_in_tx <= tx;
			core_err_code <= code;
			tick(1);
			core_err <= 1'b0;
			tick(1);
		end
	endtask

	// The receive pin passes two flip-flops, so the level settles before the sample.
	task automatic samp(input int n, input logic dom);
		repeat (n)
		begin
			node_dom <= dom;
			tick(3);
			core_sample_point <= 1'b1;
			tick(1);
			core_sample_point <= 1'b0;
		end
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			end_sim;
		end
	end

	// ============================================================
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		core_tx = 1'b1;
		core_sample_point = 1'b0;
		core_rx_ok = 1'b0;
		core_tx_ok = 1'b0;
		core_err = 1'b0;
		core_err_in_tx = 1'b0;
		core_err_code = 3'h0;
		msg_irq_id = 16'h0000;
		node_dom = 1'b0;
		tick(8);
		bchk(msg_flags_clear, 1'b1);
		bchk(can_tx_pin, 1'b1);
		bchk(irq_n, 1'b1);
		rstn <= 1'b1;
		tick(3);
		bchk(msg_flags_clear, 1'b0);
		for (i = 0; i < 26; i++)
		begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			rchk(rows[i].a, 16'hFFFF, rows[i].e);
		end
		// Loop back feeds the core's own stream back while the pin stays recessive.
		wr(8'h00, 16'h00A1);
		tick(1);
		wr(8'h0A, 16'h0010);
		core_tx <= 1'b0;
		tick(3);
		bchk(core_rx, 1'b0);
		bchk(auto_retransmit_disable, 1'b1);
		chk({9'h000, test_q}, 16'h0010);
		chk(bit_timing_q, 16'h2301);
		chk({12'h000, brp_ext_q}, 16'h000F);
		chk(tt_mode_q, 16'hFFFF);
		core_tx <= 1'b0;
		tick(3);
		bchk(can_tx_pin, 1'b1);
		wr(8'h00, 16'h0006);
		tick(3);
		bchk(can_tx_pin, 1'b0);
		core_tx <= 1'b1;
		core_rx_ok <= 1'b1;
		tick(1);
		core_rx_ok <= 1'b0;
		tick(3);
		bchk(irq_n, 1'b0);
		rchk(8'h08, 16'hFFFF, 16'h8000);
		rchk(8'h02, 16'hFFFF, 16'h0010);
		rchk(8'h08, 16'hFFFF, 16'h0000);
		bchk(irq_n, 1'b1);
		wr(8'h02, 16'h0007);
		tick(3);
		bchk(irq_n, 1'b1);
		rchk(8'h02, 16'hFFFF, 16'h0007);
		core_tx_ok <= 1'b1;
		tick(1);
		core_tx_ok <= 1'b0;
		tick(3);
		rchk(8'h08, 16'hFFFF, 16'h8000);
		rchk(8'h02, 16'hFFFF, 16'h0008);
		wr(8'h00, 16'h0004);
		tick(3);
		bchk(irq_n, 1'b1);
		for (i = 1; i < 7; i++)
		begin
			errs(1, 1'b0, i[2:0]);
			rchk(8'h02, 16'h0007, i[15:0]);
		end
		rchk(8'h04, 16'hFFFF, 16'h0600);
		msg_irq_id <= 16'h0005;
		rchk(8'h08, 16'hFFFF, 16'h0005);
		msg_irq_id <= 16'h0000;
		// Error enable only: plain bus errors stay silent until the warning flag moves.
		wr(8'h00, 16'h000A);
		errs(11, 1'b1, 3'h3);
		tick(2);
		bchk(irq_n, 1'b1);
		rchk(8'h02, 16'h0040, 16'h0000);
		errs(1, 1'b1, 3'h3);
		tick(2);
		bchk(irq_n, 1'b0);
		rchk(8'h02, 16'h0040, 16'h0040);
		rchk(8'h04, 16'hFFFF, 16'h0660);
		errs(20, 1'b1, 3'h3);
		tick(3);
		rchk(8'h02, 16'h0080, 16'h0080);
		bchk(init_hold, 1'b1);
		core_tx <= 1'b0;
		tick(3);
		bchk(can_tx_pin, 1'b1);
		core_tx <= 1'b1;
		wr(8'h00, 16'h0000);
		// A dominant sample inside the first run must restart the run.
		samp(5, 1'b0);
		samp(1, 1'b1);
		samp(1408, 1'b0);
		rchk(8'h02, 16'h0087, 16'h0085);
		samp(11, 1'b0);
		tick(3);
		rchk(8'h02, 16'h00E7, 16'h0005);
		rchk(8'h04, 16'hFFFF, 16'h0000);
		errs(32, 1'b1, 3'h3);
		tick(3);
		rchk(8'h02, 16'h0080, 16'h0080);
		rstn <= 1'b0;
		tick(8);
		bchk(msg_flags_clear, 1'b1);
		rstn <= 1'b1;
		tick(3);
		rchk(8'h02, 16'hFFFF, 16'h0000);
		rchk(8'h00, 16'hFFFF, 16'h0001);
		bchk(can_tx_pin, 1'b1);
		end_sim;
	end
endmodule

// ### verif/ccs_bus_node.sv
// Purpose: Other nodes on the shared CAN bus, folded into one wired-AND bus level.
// Assumes: Dominant is 0; the bus idles recessive through its termination.
// Notes:   The bench commands a dominant level to break recessive runs.
`timescale 1ns/100ps

// ============================================================
// Bus level
module ccs_bus_node
(
	input wire logic dut_tx,
	input wire logic drive_dominant,
	output logic bus_level
);
	// Any dominant driver wins, so one stuck node is enough to stall a recovery.
	assign bus_level = dut_tx & ~drive_dominant;
endmodule
